// >>> logic/adc_seq_pkg.sv
package adc_seq_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register indexes and byte addresses (byte address is four times the index)
  localparam logic [7:0] IDX_RESULT = 8'h70;
  localparam logic [7:0] IDX_CONTROL = 8'h71;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h72;
  localparam logic [7:0] IDX_EVENT_MASK = 8'h73;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = {2'h0, IDX_RESULT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = {2'h0, IDX_EVENT_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK = {2'h0, IDX_EVENT_MASK, 2'h0};

  // control/status field positions
  localparam int BIT_DONE = 7;
  localparam int BIT_ON = 5;
  localparam int CH_LSB = 0;
  localparam int CH_W = 3;

  // event status field positions
  localparam int EV_DONE = 0;
  localparam int EV_READY = 1;
  localparam int EV_W = 2;

  // reset values
  localparam logic [7:0] RESET_RESULT = 8'h00;
  localparam logic [CH_W-1:0] RESET_CHANNEL = 3'h0;
  localparam logic [EV_W-1:0] RESET_EVENTS = 2'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int STAB_TIME_PS = 30000000;
  localparam int STAB_CYCLES = (STAB_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_CYCLES = 64;
  localparam int SAMPLE_HALF_CYCLES = 63;
  localparam int SAMPLE_CYCLES = (SAMPLE_HALF_CYCLES + 1) / 2;
  localparam int RES_W = 8;
  localparam int BIT_CYCLES = (CONV_CYCLES - SAMPLE_CYCLES) / RES_W;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_STABILISE = 2'b01,
    ST_CONVERT = 2'b10
  } seq_state_type;

endpackage

// >>> logic/adc_sequencer_control.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control
  import adc_seq_pkg::*;
#(
  parameter int STAB_COUNT = STAB_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic halt_mode,
  input wire logic compare_high,
  output logic [CH_W-1:0] channel_select,
  output logic converter_power,
  output logic sample_hold,
  output logic [RES_W-1:0] trial_code,
  output logic irq
);

  logic aw_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_held_q;
  logic [DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic rd_fire;
  logic wr_control;
  logic wr_mask;
  logic wr_known;
  logic rd_result;
  logic rd_status;
  logic [DATA_W-1:0] rd_mux;
  logic rd_known;

  logic converter_on_q;
  logic [CH_W-1:0] channel_select_q;
  logic conversion_done_flag_q;
  logic [RES_W-1:0] conversion_result_q;
  logic [EV_W-1:0] event_status_q;
  logic [EV_W-1:0] event_mask_q;
  logic [7:0] control_view;

  seq_state_type state_q;
  logic [15:0] stab_cnt_q;
  logic enable;
  logic start_q;
  logic stab_done;
  logic abort;

  logic cmp_meta_q;
  logic cmp_sync_q;

  logic sar_done;
  logic [RES_W-1:0] sar_result;

  ////////////////////////////////////////////////////////////////
  // write channel
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // register word aligned decode
  assign wr_known = ({aw_addr_q[ADDR_W-1:2], 2'h0} == ADDR_RESULT)
                 || ({aw_addr_q[ADDR_W-1:2], 2'h0} == ADDR_CONTROL)
                 || ({aw_addr_q[ADDR_W-1:2], 2'h0} == ADDR_EVENT_STATUS)
                 || ({aw_addr_q[ADDR_W-1:2], 2'h0} == ADDR_EVENT_MASK);
  assign wr_control = wr_fire && w_strb_q[0] && {aw_addr_q[ADDR_W-1:2], 2'h0} == ADDR_CONTROL;
  assign wr_mask = wr_fire && w_strb_q[0] && {aw_addr_q[ADDR_W-1:2], 2'h0} == ADDR_EVENT_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  ////////////////////////////////////////////////////////////////
  // read channel
  assign s_axi_arready = !rvalid_q;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_result = rd_fire && {s_axi_araddr[ADDR_W-1:2], 2'h0} == ADDR_RESULT;
  assign rd_status = rd_fire && {s_axi_araddr[ADDR_W-1:2], 2'h0} == ADDR_EVENT_STATUS;

  // bits 6, 4, 3 read zero whatever software wrote
  always_comb begin
    control_view = 8'h00;
    control_view[BIT_DONE] = conversion_done_flag_q;
    control_view[BIT_ON] = converter_on_q;
    control_view[CH_LSB +: CH_W] = channel_select_q;
  end

  always_comb begin
    rd_mux = '0;
    rd_known = 1'b1;
    unique case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
      ADDR_RESULT: begin
        rd_mux[RES_W-1:0] = conversion_result_q;
      end
      ADDR_CONTROL: begin
        rd_mux[7:0] = control_view;
      end
      ADDR_EVENT_STATUS: begin
        rd_mux[EV_W-1:0] = event_status_q;
      end
      ADDR_EVENT_MASK: begin
        rd_mux[EV_W-1:0] = event_mask_q;
      end
      default: begin
        rd_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_on_q <= 1'b0;
      channel_select_q <= RESET_CHANNEL;
    end else if (wr_control) begin
      converter_on_q <= w_data_q[BIT_ON];
      channel_select_q <= w_data_q[CH_LSB +: CH_W];
    end
  end

  assign channel_select = channel_select_q;

  // done flag: a finishing conversion wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_done_flag_q <= 1'b0;
    end else if (sar_done) begin
      conversion_done_flag_q <= 1'b1;
    end else if (wr_control || rd_result) begin
      conversion_done_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_result_q <= RESET_RESULT;
    end else if (sar_done) begin
      conversion_result_q <= sar_result;
    end
  end

  ////////////////////////////////////////////////////////////////
  // event status, mask and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_status_q <= RESET_EVENTS;
    end else begin
      event_status_q[EV_DONE] <= sar_done || (event_status_q[EV_DONE] && !rd_status);
      event_status_q[EV_READY] <= stab_done || (event_status_q[EV_READY] && !rd_status);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_mask_q <= RESET_EVENTS;
    end else if (wr_mask) begin
      event_mask_q <= w_data_q[EV_W-1:0];
    end
  end

  // mask resets closed, so the converter alone raises no interrupt
  assign irq = |(event_status_q & event_mask_q);

  ////////////////////////////////////////////////////////////////
  // comparator synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      cmp_meta_q <= compare_high;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // power and conversion sequencer
  // halt powers down; the wait state has no path in here at all
  assign enable = converter_on_q && !halt_mode;
  assign stab_done = state_q == ST_STABILISE && enable && stab_cnt_q == 16'(STAB_COUNT - 1);
  assign abort = state_q != ST_CONVERT || !enable || wr_control;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_OFF;
      stab_cnt_q <= 16'h0000;
    end else if (!enable) begin
      state_q <= ST_OFF;
      stab_cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          state_q <= ST_STABILISE;
          stab_cnt_q <= 16'h0000;
        end
        ST_STABILISE: begin
          stab_cnt_q <= stab_cnt_q + 16'h0001;
          if (stab_done) begin
            state_q <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          state_q <= ST_CONVERT;
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // start on entry, after every result, and on a control write while converting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= enable && (stab_done
                 || (state_q == ST_CONVERT && (sar_done || wr_control)));
    end
  end

  assign converter_power = state_q != ST_OFF;

  sar_engine u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_q),
    .abort(abort),
    .compare_high(cmp_sync_q),
    .sample_hold(sample_hold),
    .trial_code(trial_code),
    .done(sar_done),
    .result(sar_result)
  );

endmodule // adc_sequencer_control
`default_nettype wire

// >>> logic/sar_engine.sv
`timescale 1ns/1ps
`default_nettype none
module sar_engine
  import adc_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic abort,
  input wire logic compare_high,
  output logic sample_hold,
  output logic [RES_W-1:0] trial_code,
  output logic done,
  output logic [RES_W-1:0] result
);

  logic busy_q;
  logic [5:0] cycle_q;
  logic [RES_W-1:0] code_q;
  logic [RES_W-1:0] result_q;
  logic done_q;
  logic [5:0] bit_phase;
  logic [2:0] bit_idx;
  logic [RES_W-1:0] bit_mask;
  logic [RES_W-1:0] decided;

  ////////////////////////////////////////////////////////////////
  // phase decode
  assign bit_phase = cycle_q - 6'(SAMPLE_CYCLES);
  assign bit_idx = 3'(bit_phase >> 2);
  assign bit_mask = 8'h80 >> bit_idx;
  // keep the trial bit only while input is at or above the trial level
  assign decided = compare_high ? code_q : (code_q & ~bit_mask);

  ////////////////////////////////////////////////////////////////
  // cycle counter
  always_ff @(posedge aclk) begin
    if (!aresetn || abort) begin
      busy_q <= 1'b0;
      cycle_q <= 6'h00;
    end else if (start) begin
      busy_q <= 1'b1;
      cycle_q <= 6'h00;
    end else if (busy_q) begin
      cycle_q <= cycle_q + 6'h01;
      if (cycle_q == 6'(CONV_CYCLES - 1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // successive approximation
  always_ff @(posedge aclk) begin
    if (!aresetn || abort || start) begin
      code_q <= 8'h00;
    end else if (busy_q && cycle_q >= 6'(SAMPLE_CYCLES)) begin
      if (bit_phase[1:0] == 2'h0) begin
        code_q <= code_q | bit_mask;
      end else if (bit_phase[1:0] == 2'(BIT_CYCLES - 1)) begin
        code_q <= decided;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      result_q <= RESET_RESULT;
    end else begin
      done_q <= busy_q && !abort && !start && cycle_q == 6'(CONV_CYCLES - 1);
      if (busy_q && !abort && !start && cycle_q == 6'(CONV_CYCLES - 1)) begin
        result_q <= decided;
      end
    end
  end

  assign sample_hold = busy_q && cycle_q < 6'(SAMPLE_CYCLES);
  assign trial_code = code_q;
  assign done = done_q;
  assign result = result_q;

endmodule // sar_engine
`default_nettype wire

// >>> verification/adc_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker
  import adc_seq_pkg::*;
#(
  parameter int STAB_COUNT = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic halt_mode,
  input wire logic [CH_W-1:0] channel_select,
  input wire logic converter_power,
  input wire logic sample_hold,
  input wire logic [RES_W-1:0] trial_code,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [5:0] hold_cnt_q;
  logic [15:0] pwr_cnt_q;
  ////////////////////////////////////////////////////////////
  // sampling and powered cycle counters
  always_ff @(posedge aclk) begin
    if (!aresetn || !sample_hold) begin
      hold_cnt_q <= 6'h00;
    end else begin
      hold_cnt_q <= hold_cnt_q + 6'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !converter_power) begin
      pwr_cnt_q <= 16'h0000;
    end else if (pwr_cnt_q != 16'hffff) begin
      pwr_cnt_q <= pwr_cnt_q + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////
  chk_sample_len: assert property (
    $fell(sample_hold) && converter_power && !halt_mode && !s_axi_bvalid && !$past(s_axi_bvalid)
    |-> hold_cnt_q == 6'h20) else $error("sampling phase length wrong");
  chk_stab_wait: assert property (
    $rose(sample_hold) |-> pwr_cnt_q >= STAB_COUNT) else $error("conversion before stabilisation");
  chk_power_off: assert property (
    !converter_power [*3] |-> !sample_hold && trial_code == 8'h00) else $error("activity while off");
  chk_halt_off: assert property (
    halt_mode |-> ##[1:2] !converter_power) else $error("halt left converter powered");
  chk_chan_write: assert property (
    $changed(channel_select) |-> $rose(s_axi_bvalid)) else $error("channel changed without write");
  chk_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_read_busy: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
  chk_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  cover property ($fell(sample_hold));
  cover property (irq);
  cover property (halt_mode && $past(converter_power));
endmodule // adc_seq_checker
bind adc_sequencer_control adc_seq_checker #(.STAB_COUNT(STAB_COUNT)) chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .halt_mode(halt_mode), .channel_select(channel_select),
  .converter_power(converter_power), .sample_hold(sample_hold), .trial_code(trial_code), .irq(irq));
`default_nettype wire

// >>> verification/analog_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
  import adc_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CH_W-1:0] channel_select,
  input wire logic converter_power,
  input wire logic [RES_W-1:0] trial_code,
  input wire logic [63:0] levels,
  output logic compare_high
);
  logic idle_q;
  always_ff @(posedge aclk) begin
    idle_q <= aresetn ? ~idle_q : 1'b0;
  end
  // comparator on the selected input, noise while unpowered
  assign compare_high = converter_power ? (levels[channel_select*8 +: 8] >= trial_code) : idle_q;
endmodule // analog_front_model
`default_nettype wire

// >>> verification/tb_adc_sequencer_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_adc_sequencer_control
  import adc_seq_pkg::*;
;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rexp_type;
  logic aclk = 1'b0, aresetn = 1'b0, halt_mode = 1'b0, compare_high, irq, converter_power, sample_hold;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [CH_W-1:0] channel_select;
  logic [7:0] trial_code, c, lv;
  logic [63:0] levels = '0;
  logic [15:0] lfsr_q = 16'he081;
  rexp_type exp_r[$];
  rexp_type cur;
  logic [1:0] cur_b;
  logic [1:0] exp_b[$];
  int err_total = 0, comparisons = 0;
  always #4 aclk = ~aclk;
  adc_sequencer_control #(.STAB_COUNT(8)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .halt_mode, .compare_high, .channel_select, .converter_power, .sample_hold, .trial_code, .irq);
  analog_front_model model_i (.aclk, .aresetn, .channel_select, .converter_power, .trial_code, .levels,
    .compare_high);
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw_p, w_p, ta, tw;
    exp_b.push_back(r);
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_p || w_p) begin
      @(negedge aclk);
      ta = aw_p && s_axi_awready;
      tw = w_p && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      aw_p = aw_p && !ta;
      w_p = w_p && !tw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    exp_r.push_back('{d, m, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    @(posedge aclk);
    q = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_done(input logic [7:0] ctl);
    do rd(ADDR_CONTROL, {24'h000000, ctl}, 32'hffffff7f, RESP_OKAY); while (q[BIT_DONE] !== 1'b1);
  endtask
  ////////////////////////////////////////////////////////////
  // scoreboard of bus answers
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && exp_r.size() > 0) begin
      cur = exp_r.pop_front();
      `CHK(s_axi_rdata & cur.m, cur.d)
      `CHK(s_axi_rresp, cur.r)
    end
    if (s_axi_bvalid && s_axi_bready && exp_b.size() > 0) begin
      cur_b = exp_b.pop_front();
      `CHK(s_axi_bresp, cur_b)
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    summarize();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_RESULT, 32'h0, 32'hffffffff, RESP_OKAY);
    rd(ADDR_CONTROL, 32'h0, 32'hffffffff, RESP_OKAY);
    rd(ADDR_EVENT_MASK, 32'h0, 32'hffffffff, RESP_OKAY);
    rd(12'h100, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(ADDR_RESULT, 8'h5a, RESP_OKAY);
    wr(12'h100, 8'h01, RESP_SLVERR);
    rd(ADDR_RESULT, 32'h0, 32'hffffffff, RESP_OKAY);
    for (int ch = 0; ch < 8; ch++) begin
      lfsr_q = lfsr(lfsr_q);
      lv = (ch == 0) ? 8'h00 : (ch == 7) ? 8'hff : lfsr_q[7:0];
      c = 8'h20 | 8'(ch);
      levels[ch*8 +: 8] <= lv;
      wr(ADDR_CONTROL, c | 8'h10, RESP_OKAY);
      rd(ADDR_CONTROL, {24'h0, c}, 32'hffffffff, RESP_OKAY);
      `CHK(channel_select, 3'(ch))
      wait_done(c);
      // halt freezes conversions so the flag checks cannot race a new result
      halt_mode <= 1'b1;
      rd(ADDR_RESULT, {24'h0, lv}, 32'hffffffff, RESP_OKAY);
      rd(ADDR_CONTROL, {24'h0, c}, 32'hffffffff, RESP_OKAY);
      halt_mode <= 1'b0;
    end
    rd(ADDR_EVENT_STATUS, 32'h1, 32'h1, RESP_OKAY);
    wr(ADDR_EVENT_MASK, 8'h01, RESP_OKAY);
    `CHK(irq, 1'b0)
    levels[63:56] <= 8'h3c;
    repeat (200) @(posedge aclk);
    `CHK(irq, 1'b1)
    rd(ADDR_RESULT, 32'h3c, 32'hffffffff, RESP_OKAY);
    wr(ADDR_EVENT_MASK, 8'h00, RESP_OKAY);
    `CHK(irq, 1'b0)
    halt_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK(converter_power, 1'b0)
    repeat (100) @(posedge aclk);
    rd(ADDR_EVENT_STATUS, 32'h1, 32'h1, RESP_OKAY);
    wr(ADDR_EVENT_MASK, 8'h01, RESP_OKAY);
    `CHK(irq, 1'b0)
    halt_mode <= 1'b0;
    wait_done(8'h27);
    rd(ADDR_RESULT, 32'h3c, 32'hffffffff, RESP_OKAY);
    wr(ADDR_CONTROL, 8'h07, RESP_OKAY);
    repeat (150) @(posedge aclk);
    `CHK(converter_power, 1'b0)
    rd(ADDR_CONTROL, 32'h07, 32'hffffffff, RESP_OKAY);
    summarize();
  end
endmodule // tb_adc_sequencer_control
`default_nettype wire
